// ==== rtl/iex_exec.sv ====
/*
  Execution unit for byte set, bit set, skip tests, increment and decrement with
  skip, subtract, nibble swap, table reads and XOR. Owns the accumulator, the
  table high register, the arithmetic flags and the data memory.
  Assumes the core hands over one decoded operation at a time while ready is
  high, that program memory answers rom_data combinationally from rom_addr_q,
  and that the core flushes its prefetched word when flush_q is high.
*/
`timescale 1ns/100ps
`include "iex_cfg.svh"
module iex_exec #(
  parameter int DW = `IEX_DW,
  parameter int AW = `IEX_DM_AW,
  parameter int DEPTH = `IEX_DM_DEPTH
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic op_valid,
  input wire iex_pkg::iex_op_e op_code,
  input wire logic [AW-1:0] op_addr,
  input wire logic [2:0] op_bit,
  input wire logic [DW-1:0] op_imm,
  input wire logic [DW-1:0] table_pointer,
  input wire logic [`IEX_PAGE_W-1:0] current_page,
  input wire logic [`IEX_ROM_DW-1:0] rom_data,
  input wire logic ext_we,
  input wire logic [AW-1:0] ext_addr,
  input wire logic [DW-1:0] ext_wdata,
  input wire logic acc_load,
  input wire logic [DW-1:0] acc_load_data,
  output logic ready_q,
  output logic done_q,
  output logic skipped_q,
  output logic flush_q,
  output logic [DW-1:0] acc_q,
  output logic [`IEX_TABLE_HIGH_W-1:0] table_high_byte_q,
  output logic flag_ov_q,
  output logic flag_z_q,
  output logic flag_ac_q,
  output logic flag_c_q,
  output logic [`IEX_ROM_AW-1:0] rom_addr_q,
  output logic [DW-1:0] dm_rdata
);
  iex_pkg::iex_state_e state_q, state_d;
  iex_pkg::iex_op_e op_q;
  logic [AW-1:0] addr_q;
  logic [2:0] bit_q;
  logic [DW-1:0] imm_q;

  // Result selection
  logic [DW-1:0] res;
  logic mem_we, acc_we, skip, zf_we, arith_we;
  logic [DW-1:0] sub_b, diff;
  logic sub_ov, sub_ac, sub_c;

  wire idle = (state_q == iex_pkg::ST_IDLE);
  wire exec = (state_q == iex_pkg::ST_EXEC);
  wire accept = idle && op_valid;
  wire [DW-1:0] m = dm_rdata;
  wire [DW-1:0] bit_mask = `IEX_ONE << bit_q;
  wire bit_val = m[bit_q];
  wire [DW-1:0] m_inc = m + `IEX_ONE;
  wire [DW-1:0] m_dec = m - `IEX_ONE;
  wire [DW-1:0] m_swap = {m[3:0], m[7:4]};
  wire [DW-1:0] x_mem = acc_q ^ m;
  wire [DW-1:0] x_imm = acc_q ^ imm_q;

  function automatic logic is_sub_op(input iex_pkg::iex_op_e op);
    is_sub_op = (op == iex_pkg::OP_SUB_FROM_ACC) || (op == iex_pkg::OP_SUBTRACT_TO_MEMORY)
      || (op == iex_pkg::OP_SUB_IMM);
  endfunction : is_sub_op

  function automatic logic is_xor_op(input iex_pkg::iex_op_e op);
    is_xor_op = (op == iex_pkg::OP_XOR_TO_ACC) || (op == iex_pkg::OP_XOR_TO_MEMORY)
      || (op == iex_pkg::OP_XOR_IMM);
  endfunction : is_xor_op

  assign sub_b = (op_q == iex_pkg::OP_SUB_IMM) ? imm_q : m;

  iex_alu u_alu (
    .a(acc_q),
    .b(sub_b),
    .diff(diff),
    .ov(sub_ov),
    .ac(sub_ac),
    .c(sub_c)
  );

  always_comb
  begin
    res = m;
    mem_we = 1'b0;
    acc_we = 1'b0;
    skip = 1'b0;
    unique case (op_q)
      iex_pkg::OP_SET_BYTE:
      begin
        res = `IEX_ALL_ONES; // RULE2
        mem_we = 1'b1;
      end
      iex_pkg::OP_SET_BIT:
      begin
        res = m | bit_mask; // RULE3
        mem_we = 1'b1;
      end
      iex_pkg::OP_DEC_TO_ACC_SKIP_ZERO:
      begin
        res = m_dec; // RULE1
        acc_we = 1'b1;
        skip = (m_dec == `IEX_ZERO);
      end
      iex_pkg::OP_INC_SKIP_ZERO:
      begin
        res = m_inc; // RULE5
        mem_we = 1'b1;
        skip = (m_inc == `IEX_ZERO);
      end
      iex_pkg::OP_INC_TO_ACC_SKIP_ZERO:
      begin
        res = m_inc; // RULE6
        acc_we = 1'b1;
        skip = (m_inc == `IEX_ZERO);
      end
      iex_pkg::OP_SKIP_BIT_NONZERO:
      begin
        skip = bit_val; // RULE7
      end
      iex_pkg::OP_SKIP_BIT_ZERO:
      begin
        skip = !bit_val; // RULE15
      end
      iex_pkg::OP_SKIP_IF_ZERO:
      begin
        skip = (m == `IEX_ZERO); // RULE13
      end
      iex_pkg::OP_MOVE_ACC_SKIP_ZERO:
      begin
        acc_we = 1'b1; // RULE14
        skip = (m == `IEX_ZERO);
      end
      iex_pkg::OP_SUB_FROM_ACC, iex_pkg::OP_SUB_IMM:
      begin
        res = diff; // RULE8 RULE10
        acc_we = 1'b1;
      end
      iex_pkg::OP_SUBTRACT_TO_MEMORY:
      begin
        res = diff; // RULE9
        mem_we = 1'b1;
      end
      iex_pkg::OP_NIBBLE_SWAP:
      begin
        res = m_swap; // RULE11
        mem_we = 1'b1;
      end
      iex_pkg::OP_NIBBLE_SWAP_TO_ACC:
      begin
        res = m_swap; // RULE12
        acc_we = 1'b1;
      end
      iex_pkg::OP_TABLE_READ_CURRENT_PAGE, iex_pkg::OP_TABLE_READ_LAST_PAGE:
      begin
        res = rom_data[DW-1:0]; // RULE16 RULE17
        mem_we = 1'b1;
      end
      iex_pkg::OP_XOR_TO_ACC:
      begin
        res = x_mem; // RULE18
        acc_we = 1'b1;
      end
      iex_pkg::OP_XOR_TO_MEMORY:
      begin
        res = x_mem; // RULE19
        mem_we = 1'b1;
      end
      iex_pkg::OP_XOR_IMM:
      begin
        res = x_imm; // RULE20
        acc_we = 1'b1;
      end
      default:
      begin
        res = m; // RULE21
      end
    endcase
  end

  wire is_tbl = (op_q == iex_pkg::OP_TABLE_READ_CURRENT_PAGE)
    || (op_q == iex_pkg::OP_TABLE_READ_LAST_PAGE);
  assign arith_we = exec && is_sub_op(op_q);
  assign zf_we = exec && (is_sub_op(op_q) || is_xor_op(op_q));
  wire dm_we = exec ? mem_we : (idle && !op_valid && ext_we);
  wire [AW-1:0] dm_addr = exec ? addr_q : (accept ? op_addr : ext_addr);
  wire [DW-1:0] dm_wdata = exec ? res : ext_wdata;
  wire [`IEX_PAGE_W-1:0] tbl_page = (op_code == iex_pkg::OP_TABLE_READ_LAST_PAGE)
    ? `IEX_LAST_PAGE : current_page;

  iex_dmem #(
    .DEPTH(DEPTH),
    .AW(AW),
    .DW(DW)
  ) u_dmem (
    .clk(clk),
    .addr(dm_addr),
    .we(dm_we),
    .wdata(dm_wdata),
    .rdata_q(dm_rdata)
  );

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      iex_pkg::ST_IDLE: state_d = op_valid ? iex_pkg::ST_EXEC : iex_pkg::ST_IDLE;
      iex_pkg::ST_EXEC: state_d = skip ? iex_pkg::ST_DUMMY : iex_pkg::ST_IDLE; // RULE4
      iex_pkg::ST_DUMMY: state_d = iex_pkg::ST_IDLE;
      default: state_d = iex_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= iex_pkg::ST_IDLE;
      ready_q <= 1'b0;
      done_q <= 1'b0;
      skipped_q <= 1'b0;
      flush_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      ready_q <= (state_d == iex_pkg::ST_IDLE);
      done_q <= (exec && !skip) || (state_q == iex_pkg::ST_DUMMY); // RULE4
      skipped_q <= (state_q == iex_pkg::ST_DUMMY);
      flush_q <= exec && skip; // RULE4
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      op_q <= iex_pkg::OP_SET_BYTE;
      addr_q <= '0;
      bit_q <= 3'h0;
      imm_q <= '0;
      rom_addr_q <= '0;
    end
    else if (accept)
    begin
      op_q <= op_code;
      addr_q <= op_addr;
      bit_q <= op_bit;
      imm_q <= op_imm;
      rom_addr_q <= {tbl_page, table_pointer}; // RULE16 RULE17
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acc_q <= '0;
      table_high_byte_q <= '0;
    end
    else
    begin
      if (exec && acc_we)
      begin
        acc_q <= res;
      end
      else if (idle && acc_load)
      begin
        acc_q <= acc_load_data;
      end
      if (exec && is_tbl)
      begin
        table_high_byte_q <= rom_data[`IEX_ROM_DW-1:DW]; // RULE16 RULE17
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flag_ov_q <= 1'b0;
      flag_z_q <= 1'b0;
      flag_ac_q <= 1'b0;
      flag_c_q <= 1'b0;
    end
    else
    begin
      if (zf_we)
      begin
        flag_z_q <= (res == `IEX_ZERO); // RULE8 RULE18
      end
      if (arith_we)
      begin
        flag_ov_q <= sub_ov; // RULE8 RULE9 RULE10
        flag_ac_q <= sub_ac;
        flag_c_q <= sub_c;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_flush_then_done;
    flush_q && !done_q ##1 done_q && skipped_q && !flush_q;
  endsequence

  property p_skip_two_cycles;
    exec && skip |=> s_flush_then_done;
  endproperty
  a_skip_two_cycles: assert property (p_skip_two_cycles) else $error("skip not two cycles"); // RULE4

  property p_plain_one_cycle;
    accept ##1 (exec && !skip) |=> done_q && !flush_q && !skipped_q;
  endproperty
  a_plain_one_cycle: assert property (p_plain_one_cycle) else $error("plain op not one cycle"); // RULE4

  property p_set_byte;
    exec && op_q == iex_pkg::OP_SET_BYTE |-> dm_we && dm_wdata == 8'hFF && !zf_we;
  endproperty
  a_set_byte: assert property (p_set_byte) else $error("byte set wrong"); // RULE2

  property p_set_bit;
    exec && op_q == iex_pkg::OP_SET_BIT |=> $stable(flag_z_q) && $stable(flag_c_q)
      && $past(dm_wdata) == ($past(m) | (8'h01 << $past(bit_q)));
  endproperty
  a_set_bit: assert property (p_set_bit) else $error("bit set wrong"); // RULE3

  property p_dec_acc;
    exec && op_q == iex_pkg::OP_DEC_TO_ACC_SKIP_ZERO |=> acc_q == $past(m) - 8'h01
      && flush_q == ($past(m) == 8'h01);
  endproperty
  a_dec_acc: assert property (p_dec_acc) else $error("decrement to acc wrong"); // RULE1

  property p_inc_mem;
    exec && op_q == iex_pkg::OP_INC_SKIP_ZERO |-> dm_we && dm_wdata == m + 8'h01
      ##1 flush_q == ($past(m) == 8'hFF);
  endproperty
  a_inc_mem: assert property (p_inc_mem) else $error("increment skip wrong"); // RULE5

  property p_sub_flags;
    exec && op_q == iex_pkg::OP_SUB_FROM_ACC |=> acc_q == $past(acc_q) - $past(m)
      && flag_z_q == (acc_q == 8'h00) && flag_c_q == ($past(acc_q) >= $past(m));
  endproperty
  a_sub_flags: assert property (p_sub_flags) else $error("subtract wrong"); // RULE8

  property p_swap;
    exec && op_q == iex_pkg::OP_NIBBLE_SWAP |-> dm_we && dm_wdata == {m[3:0], m[7:4]};
  endproperty
  a_swap: assert property (p_swap) else $error("nibble swap wrong"); // RULE11

  property p_xor_acc;
    exec && op_q == iex_pkg::OP_XOR_TO_ACC |=> acc_q == ($past(acc_q) ^ $past(m))
      && $stable(flag_c_q) && flag_z_q == (acc_q == 8'h00);
  endproperty
  a_xor_acc: assert property (p_xor_acc) else $error("xor to acc wrong"); // RULE18

  property p_last_page;
    accept && op_code == iex_pkg::OP_TABLE_READ_LAST_PAGE |=> rom_addr_q[11:8] == 4'hF;
  endproperty
  a_last_page: assert property (p_last_page) else $error("last page address wrong"); // RULE17
endmodule : iex_exec

// ==== rtl/iex_cfg.svh ====
/*
  Constants of the instruction execution block: widths, fixed values, page layout
  and cycle counts. Assumes it is included by bare name from rtl/.
*/
// Summary of operation
// RULE1: Decrement to accumulator: ACC gets byte minus one, memory kept, skip on zero.
// RULE2: Byte set writes FFH to the addressed byte, flags untouched.
// RULE3: Bit set forces only the selected bit to 1, flags untouched.
// RULE4: A taken skip flushes the prefetched instruction and adds one dummy cycle.
// RULE5: Increment and skip: byte plus one written back, skip when it wraps to zero.
// RULE6: Increment to accumulator: ACC gets byte plus one, memory kept, skip on zero.
// RULE7: Bit nonzero test skips when the selected bit is set, no flags.
// RULE8: Subtract memory: ACC gets ACC plus inverted byte plus one, OV Z AC C updated.
// RULE9: Subtract to memory: same subtraction and flags, result written to the byte.
// RULE10: Subtract immediate: ACC minus immediate into ACC, OV Z AC C updated.
// RULE11: Nibble swap exchanges the byte halves in place, no flags.
// RULE12: Swap to accumulator: swapped byte goes to ACC, memory kept.
// RULE13: Byte zero test skips when the byte is zero, else one cycle.
// RULE14: Move and test copies the byte into ACC and skips when it is zero.
// RULE15: Bit zero test skips when the selected bit is clear.
// RULE16: Current page table read: low byte to memory, high part to table high.
// RULE17: Last page table read: same but from the final program page.
// RULE18: XOR memory: ACC gets ACC xor byte, only zero flag updated.
// RULE19: XOR to memory: result written to the byte, zero flag updated.
// RULE20: XOR immediate: ACC xor immediate into ACC, zero flag updated.
// RULE21: Other instructions, flag encoding and fetch belong to the rest of the core.
`ifndef IEX_CFG_SVH
`define IEX_CFG_SVH
`define IEX_DW 8
`define IEX_ALL_ONES 8'hFF
`define IEX_ONE 8'h01
`define IEX_ZERO 8'h00
`define IEX_DM_DEPTH 192
`define IEX_DM_AW 8
`define IEX_ROM_DW 15
`define IEX_ROM_AW 12
`define IEX_TABLE_HIGH_W 7
`define IEX_PAGE_W 4
`define IEX_LAST_PAGE 4'hF
`define IEX_PLAIN_CYCLES 1
`define IEX_SKIP_CYCLES 2
`endif

// ==== rtl/iex_pkg.sv ====
/*
  Types of the instruction execution block: operation codes and sequencer states.
  Assumes the rest of the core encodes decoded instructions with iex_op_e.
*/
package iex_pkg;
  typedef enum logic [4:0] {
    OP_SET_BYTE = 5'h00,
    OP_SET_BIT = 5'h01,
    OP_DEC_TO_ACC_SKIP_ZERO = 5'h02,
    OP_INC_SKIP_ZERO = 5'h03,
    OP_INC_TO_ACC_SKIP_ZERO = 5'h04,
    OP_SKIP_BIT_NONZERO = 5'h05,
    OP_SKIP_BIT_ZERO = 5'h06,
    OP_SKIP_IF_ZERO = 5'h07,
    OP_MOVE_ACC_SKIP_ZERO = 5'h08,
    OP_SUB_FROM_ACC = 5'h09,
    OP_SUBTRACT_TO_MEMORY = 5'h0A,
    OP_SUB_IMM = 5'h0B,
    OP_NIBBLE_SWAP = 5'h0C,
    OP_NIBBLE_SWAP_TO_ACC = 5'h0D,
    OP_TABLE_READ_CURRENT_PAGE = 5'h0E,
    OP_TABLE_READ_LAST_PAGE = 5'h0F,
    OP_XOR_TO_ACC = 5'h10,
    OP_XOR_TO_MEMORY = 5'h11,
    OP_XOR_IMM = 5'h12
  } iex_op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_EXEC = 2'h1,
    ST_DUMMY = 2'h3
  } iex_state_e;
endpackage : iex_pkg

// ==== rtl/iex_dmem.sv ====
/*
  Byte-wide data memory with one port and registered read data.
  Assumes one access per clock; addresses beyond the depth read zero.
*/
`timescale 1ns/100ps
`include "iex_cfg.svh"
module iex_dmem #(
  parameter int DEPTH = `IEX_DM_DEPTH,
  parameter int AW = `IEX_DM_AW,
  parameter int DW = `IEX_DW
) (
  input wire logic clk,
  input wire logic [AW-1:0] addr,
  input wire logic we,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata_q
);
  logic [DW-1:0] mem [DEPTH];
  wire in_range = (32'(addr) < DEPTH);

  always_ff @(posedge clk)
  begin
    if (we && in_range)
    begin
      mem[addr] <= wdata;
    end
    rdata_q <= in_range ? mem[addr] : '0;
  end
endmodule : iex_dmem

// ==== rtl/iex_alu.sv ====
/*
  Two's complement subtractor: a plus inverted b plus one, with the
  overflow, auxiliary carry and carry results. Purely combinational.
*/
`timescale 1ns/100ps
`include "iex_cfg.svh"
module iex_alu (
  input wire logic [`IEX_DW-1:0] a,
  input wire logic [`IEX_DW-1:0] b,
  output logic [`IEX_DW-1:0] diff,
  output logic ov,
  output logic ac,
  output logic c
);
  wire [`IEX_DW:0] full = {1'b0, a} + {1'b0, ~b} + 9'h001;
  wire [4:0] low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;

  assign diff = full[`IEX_DW-1:0];
  assign c = full[`IEX_DW];
  assign ac = low[4];
  assign ov = (a[7] ^ b[7]) & (a[7] ^ full[7]);
endmodule : iex_alu

// ==== bench/tb_top.sv ====
/*
  Self-checking bench of the execution unit: every operation code, skip timing,
  flag effects and data memory results through the side port.
  Assumes iex_exec with default parameters and a 25 MHz clock.
*/
`timescale 1ns/100ps
`include "iex_cfg.svh"
module tb_top;
  logic clk, arst_n, op_valid, ext_we, acc_load;
  iex_pkg::iex_op_e op_code;
  logic [7:0] op_addr, op_imm, table_pointer, ext_addr, ext_wdata, acc_load_data;
  logic [2:0] op_bit;
  logic [3:0] current_page;
  logic [14:0] rom_data;
  logic ready_q, done_q, skipped_q, flush_q, flag_ov_q, flag_z_q, flag_ac_q, flag_c_q;
  logic [7:0] acc_q, dm_rdata;
  logic [6:0] table_high_byte_q;
  logic [11:0] rom_addr_q;
  logic [3:0] flags_x;
  int fail_count, n_compared;
  wire [3:0] flags = {flag_ov_q, flag_z_q, flag_ac_q, flag_c_q};

  iex_exec u_iex_exec (.clk(clk), .arst_n(arst_n), .op_valid(op_valid), .op_code(op_code),
    .op_addr(op_addr), .op_bit(op_bit), .op_imm(op_imm), .table_pointer(table_pointer),
    .current_page(current_page), .rom_data(rom_data), .ext_we(ext_we), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .acc_load(acc_load), .acc_load_data(acc_load_data),
    .ready_q(ready_q), .done_q(done_q), .skipped_q(skipped_q), .flush_q(flush_q),
    .acc_q(acc_q), .table_high_byte_q(table_high_byte_q), .flag_ov_q(flag_ov_q),
    .flag_z_q(flag_z_q), .flag_ac_q(flag_ac_q), .flag_c_q(flag_c_q),
    .rom_addr_q(rom_addr_q), .dm_rdata(dm_rdata));

  // Program memory word made from address bits 10 to 0, so page errors show unless only bit 11 differs
  function automatic logic [14:0] rom_word(input logic [11:0] a);
    rom_word = {a[10:4], a[7:0] ^ 8'hA5};
  endfunction : rom_word
  assign rom_data = rom_word(rom_addr_q);

  // Reference result {ov, z, ac, c, diff} of a minus b
  function automatic logic [11:0] sub_ref(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'h0, a} + {1'h0, ~b} + 9'h001;
    h = {1'h0, a[3:0]} + {1'h0, ~b[3:0]} + 5'h01;
    sub_ref = {(a[7] != b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8], s[7:0]};
  endfunction : sub_ref

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic chk_flags;
    chk("flags", {4'h0, flags_x}, {4'h0, flags});
  endtask : chk_flags

  task automatic mem_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    ext_we <= 1'h1;
    ext_addr <= a;
    ext_wdata <= v;
    @(posedge clk);
    ext_we <= 1'h0;
  endtask : mem_wr

  task automatic mem_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    ext_addr <= a;
    @(posedge clk);
    #1;
    chk("dm_rdata", exp, dm_rdata);
  endtask : mem_rd

  task automatic set_acc(input logic [7:0] v);
    @(posedge clk);
    acc_load <= 1'h1;
    acc_load_data <= v;
    @(posedge clk);
    acc_load <= 1'h0;
  endtask : set_acc

  // One operation; checks its length, skip pulse and dummy-cycle flush
  task automatic op(input iex_pkg::iex_op_e c, input logic [7:0] a, input logic [2:0] b,
    input logic [7:0] imm, input logic sk);
    int n;
    logic fl;
    n = 0;
    fl = 1'h0;
    @(posedge clk);
    op_valid <= 1'h1;
    op_code <= c;
    op_addr <= a;
    op_bit <= b;
    op_imm <= imm;
    @(posedge clk);
    op_valid <= 1'h0;
    while (done_q !== 1'h1 && n < 8)
    begin
      @(posedge clk);
      #1;
      n++;
      if (flush_q === 1'h1)
        fl = 1'h1;
    end
    chk("cycles", sk ? 8'(`IEX_SKIP_CYCLES) : 8'(`IEX_PLAIN_CYCLES), n[7:0]);
    chk("ready", 8'h01, {7'h00, ready_q});
    chk("skipped", {7'h00, sk}, {7'h00, skipped_q});
    chk("flush", {7'h00, sk}, {7'h00, fl});
  endtask : op

  task automatic t_sub;
    logic [7:0] av [5] = '{8'h05, 8'h03, 8'h80, 8'h10, 8'h42};
    logic [7:0] bv [5] = '{8'h03, 8'h05, 8'h01, 8'h01, 8'h42};
    logic [11:0] r;
    for (int i = 0; i < 5; i++)
    begin
      r = sub_ref(av[i], bv[i]);
      flags_x = r[11:8];
      mem_wr(8'h20, bv[i]);
      set_acc(av[i]);
      op(iex_pkg::OP_SUB_FROM_ACC, 8'h20, 3'h0, 8'h00, 1'h0);
      chk("acc", r[7:0], acc_q);
      chk_flags();
      set_acc(av[i]);
      op(iex_pkg::OP_SUBTRACT_TO_MEMORY, 8'h20, 3'h0, 8'h00, 1'h0);
      mem_rd(8'h20, r[7:0]);
      chk("acc", av[i], acc_q);
      chk_flags();
      set_acc(av[i]);
      op(iex_pkg::OP_SUB_IMM, 8'h21, 3'h0, bv[i], 1'h0);
      chk("acc", r[7:0], acc_q);
      chk_flags();
    end
  endtask : t_sub

  task automatic t_set;
    mem_wr(8'h10, 8'h00);
    op(iex_pkg::OP_SET_BYTE, 8'h10, 3'h0, 8'h00, 1'h0);
    mem_rd(8'h10, `IEX_ALL_ONES);
    mem_wr(8'h11, 8'h00);
    op(iex_pkg::OP_SET_BIT, 8'h11, 3'h5, 8'h00, 1'h0);
    op(iex_pkg::OP_SET_BIT, 8'h11, 3'h7, 8'h00, 1'h0);
    mem_rd(8'h11, 8'hA0);
    chk_flags();
  endtask : t_set

  task automatic t_incdec;
    mem_wr(8'h30, 8'hFF);
    op(iex_pkg::OP_INC_SKIP_ZERO, 8'h30, 3'h0, 8'h00, 1'h1);
    mem_rd(8'h30, 8'h00);
    op(iex_pkg::OP_INC_SKIP_ZERO, 8'h30, 3'h0, 8'h00, 1'h0);
    mem_rd(8'h30, 8'h01);
    op(iex_pkg::OP_DEC_TO_ACC_SKIP_ZERO, 8'h30, 3'h0, 8'h00, 1'h1);
    chk("acc", 8'h00, acc_q);
    mem_rd(8'h30, 8'h01);
    mem_wr(8'h31, 8'h00);
    op(iex_pkg::OP_DEC_TO_ACC_SKIP_ZERO, 8'h31, 3'h0, 8'h00, 1'h0);
    chk("acc", 8'hFF, acc_q);
    op(iex_pkg::OP_INC_TO_ACC_SKIP_ZERO, 8'h31, 3'h0, 8'h00, 1'h0);
    chk("acc", 8'h01, acc_q);
    mem_wr(8'h31, 8'hFF);
    op(iex_pkg::OP_INC_TO_ACC_SKIP_ZERO, 8'h31, 3'h0, 8'h00, 1'h1);
    chk("acc", 8'h00, acc_q);
    mem_rd(8'h31, 8'hFF);
    chk_flags();
  endtask : t_incdec

  task automatic t_tests;
    mem_wr(8'h40, 8'h00);
    mem_wr(8'h41, 8'h81);
    op(iex_pkg::OP_SKIP_IF_ZERO, 8'h40, 3'h0, 8'h00, 1'h1);
    op(iex_pkg::OP_SKIP_IF_ZERO, 8'h41, 3'h0, 8'h00, 1'h0);
    set_acc(8'h5A);
    op(iex_pkg::OP_MOVE_ACC_SKIP_ZERO, 8'h40, 3'h0, 8'h00, 1'h1);
    chk("acc", 8'h00, acc_q);
    op(iex_pkg::OP_MOVE_ACC_SKIP_ZERO, 8'h41, 3'h0, 8'h00, 1'h0);
    chk("acc", 8'h81, acc_q);
    op(iex_pkg::OP_SKIP_BIT_NONZERO, 8'h41, 3'h7, 8'h00, 1'h1);
    op(iex_pkg::OP_SKIP_BIT_NONZERO, 8'h41, 3'h1, 8'h00, 1'h0);
    op(iex_pkg::OP_SKIP_BIT_ZERO, 8'h41, 3'h0, 8'h00, 1'h0);
    op(iex_pkg::OP_SKIP_BIT_ZERO, 8'h41, 3'h6, 8'h00, 1'h1);
    chk_flags();
  endtask : t_tests

  task automatic t_swap;
    mem_wr(8'h50, 8'h1E);
    op(iex_pkg::OP_NIBBLE_SWAP_TO_ACC, 8'h50, 3'h0, 8'h00, 1'h0);
    chk("acc", 8'hE1, acc_q);
    mem_rd(8'h50, 8'h1E);
    op(iex_pkg::OP_NIBBLE_SWAP, 8'h50, 3'h0, 8'h00, 1'h0);
    mem_rd(8'h50, 8'hE1);
    chk_flags();
  endtask : t_swap

  task automatic t_table;
    logic [14:0] w;
    @(posedge clk);
    table_pointer <= 8'h9C;
    current_page <= 4'h3;
    w = rom_word({4'h3, 8'h9C});
    op(iex_pkg::OP_TABLE_READ_CURRENT_PAGE, 8'h60, 3'h0, 8'h00, 1'h0);
    chk("table_high", {1'h0, w[14:8]}, {1'h0, table_high_byte_q});
    mem_rd(8'h60, w[7:0]);
    @(posedge clk);
    table_pointer <= 8'h47;
    w = rom_word({`IEX_LAST_PAGE, 8'h47});
    op(iex_pkg::OP_TABLE_READ_LAST_PAGE, 8'h61, 3'h0, 8'h00, 1'h0);
    chk("table_high", {1'h0, w[14:8]}, {1'h0, table_high_byte_q});
    mem_rd(8'h61, w[7:0]);
  endtask : t_table

  task automatic t_xor;
    mem_wr(8'h70, 8'h5A);
    set_acc(8'h5A);
    op(iex_pkg::OP_XOR_TO_ACC, 8'h70, 3'h0, 8'h00, 1'h0);
    chk("acc", 8'h00, acc_q);
    flags_x[2] = 1'h1;
    chk_flags();
    set_acc(8'hF0);
    op(iex_pkg::OP_XOR_TO_MEMORY, 8'h70, 3'h0, 8'h00, 1'h0);
    mem_rd(8'h70, 8'hAA);
    chk("acc", 8'hF0, acc_q);
    flags_x[2] = 1'h0;
    chk_flags();
    op(iex_pkg::OP_XOR_IMM, 8'h00, 3'h0, 8'hF0, 1'h0);
    chk("acc", 8'h00, acc_q);
    flags_x[2] = 1'h1;
    chk_flags();
  endtask : t_xor

  task automatic stop_test;
    if (fail_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    arst_n = 1'h0;
    op_valid = 1'h0;
    op_code = iex_pkg::OP_SET_BYTE;
    op_addr = 8'h00;
    op_bit = 3'h0;
    op_imm = 8'h00;
    table_pointer = 8'h00;
    current_page = 4'h0;
    ext_we = 1'h0;
    ext_addr = 8'h00;
    ext_wdata = 8'h00;
    acc_load = 1'h0;
    acc_load_data = 8'h00;
    fail_count = 0;
    n_compared = 0;
    repeat (16) @(posedge clk);
    arst_n <= 1'h1;
    #1;
    chk("ready", 8'h00, {7'h00, ready_q});
    @(posedge clk);
    #1;
    chk("ready", 8'h01, {7'h00, ready_q});
    @(posedge clk);
    t_sub();
    t_set();
    t_incdec();
    t_tests();
    t_swap();
    t_table();
    t_xor();
    stop_test();
  end

  // Whole run is well under 2000 cycles
  initial
  begin
    #400000;
    fail_count++;
    stop_test();
  end
endmodule : tb_top
